// [hw/psti_pkg.sv]
// psti_pkg: constants for the supply's two-wire target port
// assumes a 20 MHz system clock sampling the bus pins
package psti_pkg;
    localparam int unsigned CLK_HZ = 20000000; // system clock rate
    localparam int unsigned BUS_HZ = 100000; // nominal serial clock rate
    localparam int unsigned SCL_LOW_NS = 1300; // least serial clock low time
    localparam int unsigned CLK_NS = 50; // system clock period
    // cycles in the shortest low phase, rounded up
    localparam int unsigned SCL_LOW_CYC = (SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ADDR_HI = 4'hA; // fixed upper address nibble 1010
    localparam logic [2:0] UNIT_RST = 3'h0; // unit select before first capture
    localparam logic [7:0] OFFSET_RST = 8'h00; // offset pointer after reset
    localparam logic [2:0] BIT_LAST = 3'h7; // last bit index of a byte
    localparam int unsigned SYNC_STAGES = 2; // pin synchroniser depth
endpackage : psti_pkg

// [hw/psti_sync.sv]
// psti_sync: two-stage synchroniser for asynchronous pin levels
// assumes inputs come from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module psti_sync #(
    parameter int unsigned WIDTH = 1 // number of bits carried
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    input wire logic [WIDTH-1:0] rst_val, // level shown during reset
    output logic [WIDTH-1:0] sync_out // synchronised levels
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
    // two flops in series; reset value is the idle level of the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= rst_val;
            sync_out <= rst_val;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // psti_sync
`default_nettype wire

// [hw/psti_target.sv]
// psti_target: two-wire target port, offset plus one data byte framing
// assumes bus pins are asynchronous and pulled up outside; the serial
// clock is far slower than CLOCK so its edges are found by sampling.
// Notes on behaviour
// - works with a 100 kHz serial clock
// - serial clock is input only; bits follow it
// - data line only pulled low or released
// - address is 1010 plus three unit-select bits
// - unit zero gives 0x50, seven gives 0x57
// - write: address, offset, data, all acknowledged
// - read: offset, repeated start, one byte returned
// - data change while clock high is start/stop
`timescale 1ns/100ps
`default_nettype none
module psti_target
    import psti_pkg::*;
(
    input wire logic CLOCK, // system clock, 20 MHz
    input wire logic RST_N, // synchronous reset, active low
    input wire logic SCL_IN, // serial clock pin level
    input wire logic SDA_IN, // serial data pin level
    output logic SDA_OE, // high while pulling data line low
    output logic SDA_OUT, // data drive level, always low
    input wire logic UNIT_SELECT_BIT0, // front-panel switch bit 0
    input wire logic UNIT_SELECT_BIT1, // front-panel switch bit 1
    input wire logic UNIT_SELECT_BIT2, // front-panel switch bit 2
    output logic [7:0] REGISTER_OFFSET_BYTE, // offset pointer
    output logic [7:0] PAYLOAD_BYTE, // last written data byte
    output logic WR_STROBE, // one cycle: payload written at offset
    output logic RD_REQ, // one cycle: supply data for offset
    input wire logic [7:0] RD_DATA, // data at offset, same clock
    output logic BUSY // high between start and stop
);
    import psti_pkg::*;

    typedef enum {ST_IDLE, ST_START_HOLD, ST_ADDR, ST_ADDR_ACK, ST_OFFSET, ST_OFF_ACK,
        ST_WDATA, ST_WD_ACK, ST_RDATA, ST_RD_ACK, ST_IGNORE} psti_state_t;

    logic [4:0] pins_s; // synchronised scl, sda, unit select
    logic scl_s, sda_s, scl_prev_q, sda_prev_q; // levels and history
    logic scl_rise, scl_fall, start_det, stop_det; // bus events
    logic [2:0] unit_s; // synchronised switch setting
    logic [6:0] my_addr; // own 7-bit address
    psti_state_t state_q; // protocol state
    logic [2:0] bit_q; // bit counter within byte
    logic [7:0] shift_q; // receive shift register
    logic [7:0] tx_q; // transmit shift register
    logic [7:0] rx_byte; // byte completed at this rising edge

    // pins are asynchronous: two flops before any use
    psti_sync #(.WIDTH(5)) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .async_in({UNIT_SELECT_BIT2, UNIT_SELECT_BIT1, UNIT_SELECT_BIT0, SDA_IN, SCL_IN}),
        .rst_val(5'h03),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign unit_s = pins_s[4:2];
    assign my_addr = {ADDR_HI, unit_s};

    // previous levels for edge detection
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // 50 ns sampling sees each 5 us half period about 100 times
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    // data edges with clock held high mark frame limits
    assign start_det = scl_s && scl_prev_q && !sda_s && sda_prev_q;
    assign stop_det = scl_s && scl_prev_q && sda_s && !sda_prev_q;
    assign rx_byte = {shift_q[6:0], sda_s};

    // protocol sequencer; a start is honoured in any state so a
    // repeated start restarts address reception
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (start_det) begin
            state_q <= ST_START_HOLD;
            bit_q <= 3'h0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bit_q <= 3'h0; // wait for a start
                end
                ST_START_HOLD: begin
                    // the clock fall that ends a start is not a data bit,
                    // so bit counting begins only after it
                    if (scl_fall) begin
                        state_q <= ST_ADDR;
                        bit_q <= 3'h0;
                    end
                end
                ST_ADDR, ST_OFFSET, ST_WDATA: begin
                    // sample data on rising clock edge
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                    end
                    if (scl_fall) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            case (state_q)
                                ST_ADDR: begin
                                    if (shift_q[7:1] == my_addr) begin
                                        state_q <= ST_ADDR_ACK;
                                    end else begin
                                        state_q <= ST_IGNORE;
                                    end
                                end
                                ST_OFFSET: state_q <= ST_OFF_ACK;
                                default: state_q <= ST_WD_ACK;
                            endcase
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_q <= 3'h0;
                        // direction bit 1 reads from the current pointer
                        if (shift_q[0]) begin
                            state_q <= ST_RDATA;
                        end else begin
                            state_q <= ST_OFFSET;
                        end
                    end
                end
                ST_OFF_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_WDATA;
                    end
                end
                ST_WD_ACK: begin
                    // single byte framing: later bytes are ignored
                    if (scl_fall) begin
                        state_q <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            state_q <= ST_RD_ACK;
                        end
                    end
                end
                ST_RD_ACK: begin
                    // controller's answer is not needed: one byte per read
                    if (scl_fall) begin
                        state_q <= ST_IGNORE; // one byte per read
                    end
                end
                ST_IGNORE: begin
                    bit_q <= 3'h0; // sit out until start or stop
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // offset pointer and payload capture, strobe on acknowledged byte
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            REGISTER_OFFSET_BYTE <= OFFSET_RST;
            PAYLOAD_BYTE <= 8'h00;
            WR_STROBE <= 1'b0;
        end else begin
            WR_STROBE <= 1'b0;
            if (scl_fall && bit_q == BIT_LAST && !start_det && !stop_det) begin
                if (state_q == ST_OFFSET) begin
                    REGISTER_OFFSET_BYTE <= shift_q;
                end
                if (state_q == ST_WDATA) begin
                    PAYLOAD_BYTE <= shift_q;
                    WR_STROBE <= 1'b1;
                end
            end
        end
    end

    // read fetch: request on the address acknowledge, load a cycle later;
    // the supplier must present the byte at the pointer in the request cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            RD_REQ <= 1'b0;
            tx_q <= 8'h00;
        end else begin
            RD_REQ <= (state_q == ST_ADDR_ACK) && scl_fall && shift_q[0];
            if (RD_REQ) begin
                tx_q <= RD_DATA;
            end else if (state_q == ST_RDATA && scl_fall) begin
                tx_q <= {tx_q[6:0], 1'b1};
            end
        end
    end

    // data line driver: only ever pulls low, changes while clock is low
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            SDA_OE <= 1'b0;
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            case (state_q)
                ST_ADDR_ACK, ST_OFF_ACK, ST_WD_ACK: SDA_OE <= !scl_s || SDA_OE;
                ST_RDATA: SDA_OE <= !tx_q[7] && !(RD_REQ);
                default: SDA_OE <= 1'b0;
            endcase
            if (start_det || stop_det) begin
                SDA_OE <= 1'b0;
            end
        end
    end

    // bus busy flag mirrors start to stop
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            BUSY <= 1'b0;
        end else if (start_det) begin
            BUSY <= 1'b1;
        end else if (stop_det) begin
            BUSY <= 1'b0;
        end
    end
endmodule // psti_target
`default_nettype wire

// [verif/psti_chk.sv]
// psti_chk: pin-level checks on the two-wire target port
// assumes it is bound into psti_target, with the bus pulled up outside
`timescale 1ns/100ps
`default_nettype none
module psti_chk (
    input wire logic CLOCK, // system clock
    input wire logic RST_N, // sync reset, active low
    input wire logic SCL_IN, // serial clock level
    input wire logic SDA_IN, // serial data level
    input wire logic SDA_OE, // data pull enable
    input wire logic SDA_OUT, // data drive level
    input wire logic [7:0] REGISTER_OFFSET_BYTE, // offset pointer
    input wire logic [7:0] PAYLOAD_BYTE, // written data
    input wire logic WR_STROBE, // write pulse
    input wire logic RD_REQ, // fetch pulse
    input wire logic BUSY // transfer open
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // raw pin edges; the design sees them a few cycles late through its synchroniser
    sequence start_s; $fell(SDA_IN) && SCL_IN && $past(SCL_IN); endsequence
    sequence stop_s; $rose(SDA_IN) && SCL_IN && $past(SCL_IN); endsequence
    sda_low_only_a: assert property (SDA_OUT == 1'b0)
        else $error("data line driven high");
    start_busy_a: assert property (start_s |-> ##[1:6] BUSY)
        else $error("start not followed by busy");
    stop_idle_a: assert property (stop_s |-> ##[1:6] !BUSY)
        else $error("stop not followed by idle");
    wr_pulse_a: assert property (WR_STROBE |=> !WR_STROBE)
        else $error("write strobe longer than one cycle");
    wr_busy_a: assert property (WR_STROBE |-> BUSY)
        else $error("write strobe outside transfer");
    rd_pulse_a: assert property (RD_REQ |=> !RD_REQ)
        else $error("fetch pulse longer than one cycle");
    rd_busy_a: assert property (RD_REQ |-> BUSY)
        else $error("fetch outside transfer");
    pull_busy_a: assert property (SDA_OE |-> BUSY)
        else $error("data pulled outside transfer");
    offset_idle_a: assert property (!BUSY ##1 !BUSY |-> $stable(REGISTER_OFFSET_BYTE))
        else $error("pointer moved on idle bus");
    payload_src_a: assert property ($changed(PAYLOAD_BYTE) |-> WR_STROBE)
        else $error("payload changed without strobe");
    // main scenarios reached
    cover property (WR_STROBE);
    cover property (RD_REQ);
    cover property (start_s ##[1:6] BUSY);
endmodule // psti_chk
bind psti_target psti_chk i_psti_chk (.CLOCK(CLOCK), .RST_N(RST_N), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .SDA_OUT(SDA_OUT),
    .REGISTER_OFFSET_BYTE(REGISTER_OFFSET_BYTE), .PAYLOAD_BYTE(PAYLOAD_BYTE),
    .WR_STROBE(WR_STROBE), .RD_REQ(RD_REQ), .BUSY(BUSY));
`default_nettype wire

// [verif/psti_ctrl_model.sv]
// psti_ctrl_model: bus controller making the serial clock and pulling data low
// assumes the bench resolves the data wire with a pull-up; period 8 CLOCK cycles
`timescale 1ns/100ps
`default_nettype none
module psti_ctrl_model (
    input wire logic clk, // bench clock
    input wire logic sda, // resolved data wire
    output logic scl, // serial clock, stands high between frames
    output logic sda_pull // high while pulling data low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // whole cycles only, so every pin change follows an edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data set late in the low phase, after the target's release, held while high
    task automatic bitx(input logic b, output logic r);
        tk(5);
        sda_pull <= !b;
        tk(1);
        scl <= 1'b1;
        tk(2);
        r = sda;
        scl <= 1'b0;
    endtask
    // also serves as repeated start; only used on an idle bus or inside our frame
    task automatic start();
        tk(5);
        sda_pull <= 1'b0;
        tk(1);
        scl <= 1'b1;
        tk(4);
        sda_pull <= 1'b1;
        tk(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tk(5);
        sda_pull <= 1'b1;
        tk(1);
        scl <= 1'b1;
        tk(4);
        sda_pull <= 1'b0;
        tk(8);
    endtask
    task automatic byte_tx(input logic [7:0] b, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r); // msb first
        bitx(1'b1, nak); // ack slot left to the target
    endtask
    task automatic byte_rx(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            b[i] = r;
        end
        bitx(1'b1, r); // single byte, so refuse more
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d, output logic [2:0] n);
        start();
        byte_tx({a, 1'b0}, n[2]);
        byte_tx(o, n[1]);
        byte_tx(d, n[0]);
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d,
        output logic [2:0] n);
        start();
        byte_tx({a, 1'b0}, n[2]);
        byte_tx(o, n[1]);
        start();
        byte_tx({a, 1'b1}, n[0]);
        byte_rx(d);
        stop();
    endtask
endmodule // psti_ctrl_model
`default_nettype wire

// [verif/tb_psti_target.sv]
// tb_psti_target: self-checking bench for the target port
// assumes psti_pkg, psti_target, psti_chk and psti_ctrl_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_psti_target;
    import psti_pkg::*;
    logic clk = 1'b0; // system clock, 50 ns
    logic rst_n = 1'b0; // held low for 10 cycles
    logic [2:0] unit = 3'h0; // front-panel switch
    logic scl, pull, oe, so, wr, rq, busy;
    logic [7:0] off, pay, wr_off, wr_pay;
    int errors = 0;
    int check_count = 0;
    int wr_seen = 0; // strobes counted
    int rd_seen = 0; // fetch pulses counted
    wire sda = !(pull || oe); // open-drain wire with pull-up
    wire [7:0] rd_data = off ^ 8'h5A; // fetch data follows the pointer
    always #25 clk = ~clk;
    // capture what each write strobe delivered
    always @(posedge clk) begin
        if (wr) begin
            wr_seen <= wr_seen + 1;
            wr_off <= off;
            wr_pay <= pay;
        end
        if (rq) begin
            rd_seen <= rd_seen + 1;
        end
    end
    psti_target i_psti_target (.CLOCK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OE(oe), .SDA_OUT(so), .UNIT_SELECT_BIT0(unit[0]), .UNIT_SELECT_BIT1(unit[1]),
        .UNIT_SELECT_BIT2(unit[2]), .REGISTER_OFFSET_BYTE(off), .PAYLOAD_BYTE(pay),
        .WR_STROBE(wr), .RD_REQ(rq), .RD_DATA(rd_data), .BUSY(busy));
    psti_ctrl_model i_psti_ctrl_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
    task automatic chk(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // after reset: line released, idle, pointer and payload cleared
    task automatic t_reset();
        chk({oe, so, busy, 5'h00}, 8'h00);
        chk(off, OFFSET_RST);
        chk(pay, 8'h00);
    endtask
    // each switch position answers at the fixed nibble plus its value
    task automatic t_units();
        logic [2:0] n;
        for (int u = 0; u < 8; u++) begin
            unit <= u[2:0];
            i_psti_ctrl_model.wr({ADDR_HI, u[2:0]}, 8'h10 + u[7:0], 8'hA0 + u[7:0], n);
            chk({5'h00, n}, 8'h00);
            chk(wr_off, 8'h10 + u[7:0]);
            chk(wr_pay, 8'hA0 + u[7:0]);
            chk({7'h00, busy}, 8'h00);
        end
        chk(wr_seen[7:0], 8'h08);
    endtask
    // foreign addresses, one differing only in the upper nibble
    task automatic t_foreign();
        logic [2:0] n;
        logic [6:0] bad [3] = '{7'h54, 7'h58, 7'h13};
        unit <= 3'h3;
        foreach (bad[k]) begin
            i_psti_ctrl_model.wr(bad[k], 8'h33, 8'hEE, n);
            chk({5'h00, n}, 8'h07);
            chk(off, 8'h17);
        end
        chk(wr_seen[7:0], 8'h08);
    endtask
    // two single-byte reads, low offset first
    task automatic t_read();
        logic [2:0] n;
        logic [7:0] d;
        for (int k = 0; k < 2; k++) begin
            i_psti_ctrl_model.rd({ADDR_HI, 3'h3}, 8'h60 + k[7:0], d, n);
            chk({5'h00, n}, 8'h00);
            chk(d, (8'h60 + k[7:0]) ^ 8'h5A);
            chk(rd_seen[7:0], 8'h01 + k[7:0]);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_units();
        t_foreign();
        t_read();
        tally_and_finish();
    end
    // hang guard, well beyond the run's length
    initial begin
        #4000000;
        errors++;
        tally_and_finish();
    end
endmodule // tb_psti_target
`default_nettype wire
